// >>> hw/spt_timer.sv
// Top of the 16-bit period timer with its register port and interrupt logic.
//
// Functional notes
// - 16-bit counter: timer, sync or async counter.
// - Interrupt when count matches period register.
// - Gated mode counts while gate high, interrupts on fall.
// - Control bit 15 starts and stops counting.
// - Bit 13 picks Idle behaviour; async counts in Sleep.
// - Bit 1 picks internal half clock or extended source.
// - Bits 9-8 pick which extended source.
// - Bits 5-4 prescale 1, 8, 64 or 256.
// - Bit 2 picks sync or async external mode; both pass the synchroniser.
// - Interrupt gated by enable, carries three-bit priority.
// - Control write while running clears prescaler.
// - Unimplemented control bits ignore writes, read zero.
`timescale 1ns/100ps
`default_nettype none

module spt_timer #(
    parameter int unsigned COUNT_W = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire spt_pkg::spt_bus_req_t bus_req,
    output var logic [spt_pkg::SPT_DATA_W-1:0] rd_data,
    input wire spt_pkg::spt_pins_t pins,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    output var logic irq,
    output var logic [2:0] irq_priority
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.

    spt_pkg::spt_control_t control_reg;
    logic [COUNT_W-1:0] period_reg;
    logic [COUNT_W-1:0] count_reg;
    logic int_enable_reg;
    logic [spt_pkg::SPT_EVT_W-1:0] status_reg;
    logic [spt_pkg::SPT_EVT_W-1:0] status_next;
    logic [spt_pkg::SPT_EVT_W-1:0] mask_reg;
    logic [7:0] prescale_reg;
    logic half_reg;
    logic ext_level_d_reg;
    logic gate_level_d_reg;

    logic wr_control;
    logic wr_period;
    logic wr_count;
    logic wr_int_ctrl;
    logic wr_mask;
    logic rd_status;
    logic ext_pin;
    logic ext_level;
    logic gate_level;
    logic ext_rise;
    logic source_tick;
    logic halted;
    logic idle_halt;
    logic sleep_halt;
    logic gate_mode;
    logic gate_open;
    logic prescale_en;
    logic [7:0] prescale_limit;
    logic count_tick;
    logic match_event;
    logic gate_fall_event;
    logic [spt_pkg::SPT_EVT_W-1:0] events;
    logic [spt_pkg::SPT_DATA_W-1:0] rd_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode.

    assign wr_control = bus_req.wr_strobe && (bus_req.addr == spt_pkg::SPT_OFS_CONTROL);
    assign wr_period = bus_req.wr_strobe && (bus_req.addr == spt_pkg::SPT_OFS_PERIOD);
    assign wr_count = bus_req.wr_strobe && (bus_req.addr == spt_pkg::SPT_OFS_COUNT);
    assign wr_int_ctrl = bus_req.wr_strobe && (bus_req.addr == spt_pkg::SPT_OFS_INT_CTRL);
    assign wr_mask = bus_req.wr_strobe && (bus_req.addr == spt_pkg::SPT_OFS_MASK);
    assign rd_status = bus_req.rd_strobe && (bus_req.addr == spt_pkg::SPT_OFS_STATUS);

    always_ff @(posedge clock) begin
        if (reset) begin
            control_reg <= spt_pkg::spt_control_t'(spt_pkg::SPT_CONTROL_RESET);
        end else if (wr_control) begin
            control_reg <= spt_pkg::spt_control_t'(bus_req.wr_data[15:0]
                & spt_pkg::SPT_CONTROL_WMASK);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            period_reg <= spt_pkg::SPT_PERIOD_RESET;
        end else if (wr_period) begin
            period_reg <= bus_req.wr_data[COUNT_W-1:0];
        end
    end

    // The enable gates the interrupt line; the priority is only passed out.
    always_ff @(posedge clock) begin
        if (reset) begin
            int_enable_reg <= 1'b0;
            irq_priority <= spt_pkg::SPT_INT_PRIO_RESET;
        end else if (wr_int_ctrl) begin
            int_enable_reg <= bus_req.wr_data[spt_pkg::SPT_INT_ENABLE_BIT];
            irq_priority <= bus_req.wr_data[spt_pkg::SPT_INT_PRIO_LSB +: 3];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mask_reg <= spt_pkg::SPT_EVT_RESET;
        end else if (wr_mask) begin
            mask_reg <= bus_req.wr_data[spt_pkg::SPT_EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock sources.

    // Selected extended source, picked before the synchroniser.
    // Changing the selection can pass for one edge, so switch it with the timer stopped.
    always_comb begin
        unique case (control_reg.extended_clock_select)
            spt_pkg::SPT_EXT_GENERIC_TIMER: ext_pin = pins.generic_timer_clock_input;
            spt_pkg::SPT_EXT_LOW_POWER_RC: ext_pin = pins.low_power_rc_oscillator;
            spt_pkg::SPT_EXT_CLOCK_INPUT: ext_pin = pins.external_clock_input;
            spt_pkg::SPT_EXT_SECONDARY_OSC: ext_pin = pins.secondary_oscillator;
        endcase
    end

    spt_sync3 u_ext_sync (
        .clock(clock),
        .reset(reset),
        .pin_in(ext_pin),
        .level(ext_level)
    );

    spt_sync3 u_gate_sync (
        .clock(clock),
        .reset(reset),
        .pin_in(pins.gate_input),
        .level(gate_level)
    );

    // Delayed levels feed the edge detectors; they reset to the idle low level of the pins.
    always_ff @(posedge clock) begin
        if (reset) begin
            ext_level_d_reg <= 1'b0;
            gate_level_d_reg <= 1'b0;
        end else begin
            ext_level_d_reg <= ext_level;
            gate_level_d_reg <= gate_level;
        end
    end

    // Internal source runs at half the system clock.
    always_ff @(posedge clock) begin
        if (reset) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
        end
    end

    assign ext_rise = ext_level && !ext_level_d_reg;
    assign source_tick = control_reg.clock_source_select ? ext_rise : half_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Idle and Sleep.

    // Idle halts the count only when idle_stop is set.
    assign idle_halt = cpu_idle && control_reg.idle_stop;

    // A synchronised or internal source stops in Sleep; only the
    // asynchronous external count keeps going.
    assign sleep_halt = cpu_sleep && !(control_reg.clock_source_select
        && !control_reg.external_clock_sync);
    assign halted = idle_halt || sleep_halt;

    // Gated accumulation applies only while the internal source is selected.
    assign gate_mode = control_reg.gate_accumulate && !control_reg.clock_source_select;
    assign gate_open = !gate_mode || gate_level;

    // Each enabled source tick advances the prescaler by one.
    assign prescale_en = control_reg.timer_run && !halted && source_tick && gate_open;

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler.

    always_comb begin
        unique case (control_reg.prescale_select)
            spt_pkg::SPT_PRE_DIV1: prescale_limit = spt_pkg::SPT_PRE_LIMIT_1;
            spt_pkg::SPT_PRE_DIV8: prescale_limit = spt_pkg::SPT_PRE_LIMIT_8;
            spt_pkg::SPT_PRE_DIV64: prescale_limit = spt_pkg::SPT_PRE_LIMIT_64;
            spt_pkg::SPT_PRE_DIV256: prescale_limit = spt_pkg::SPT_PRE_LIMIT_256;
        endcase
    end

    // A control write clears the prescaler and swallows the tick of that cycle,
    // so a rewrite while running restarts the division.
    always_ff @(posedge clock) begin
        if (reset) begin
            prescale_reg <= 8'h00;
        end else if (!control_reg.timer_run || wr_control) begin
            prescale_reg <= 8'h00;
        end else if (prescale_en) begin
            if (prescale_reg >= prescale_limit) begin
                prescale_reg <= 8'h00;
            end else begin
                prescale_reg <= prescale_reg + 8'h01;
            end
        end
    end

    assign count_tick = prescale_en && !wr_control && (prescale_reg >= prescale_limit);

    ////////////////////////////////////////////////////////////////////////////////
    // Counter.

    // The count wraps to zero on the tick after it reached the period.
    assign match_event = count_tick && (count_reg == period_reg);

    // A software write to the count wins over a tick in the same cycle.
    always_ff @(posedge clock) begin
        if (reset) begin
            count_reg <= spt_pkg::SPT_COUNT_RESET;
        end else if (wr_count) begin
            count_reg <= bus_req.wr_data[COUNT_W-1:0];
        end else if (count_tick) begin
            if (count_reg == period_reg) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status.

    assign gate_fall_event = gate_mode && control_reg.timer_run
        && gate_level_d_reg && !gate_level;

    always_comb begin
        events = '0;
        events[spt_pkg::SPT_EVT_MATCH] = match_event;
        events[spt_pkg::SPT_EVT_GATE_FALL] = gate_fall_event;
        status_next = rd_status ? events : (status_reg | events);
    end

    // An event in the cycle of a clearing read stays set.
    always_ff @(posedge clock) begin
        if (reset) begin
            status_reg <= spt_pkg::SPT_EVT_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // The interrupt line trails the status by one cycle because it is registered.
    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= int_enable_reg && |(status_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port.

    // Only a read strobe puts data on the port; all other cycles read zero.
    always_comb begin
        rd_next = '0;
        if (bus_req.rd_strobe) begin
            unique case (bus_req.addr)
                spt_pkg::SPT_OFS_CONTROL: rd_next[15:0] = control_reg;
                spt_pkg::SPT_OFS_PERIOD: rd_next[COUNT_W-1:0] = period_reg;
                spt_pkg::SPT_OFS_COUNT: rd_next[COUNT_W-1:0] = count_reg;
                spt_pkg::SPT_OFS_INT_CTRL: begin
                    rd_next[spt_pkg::SPT_INT_ENABLE_BIT] = int_enable_reg;
                    rd_next[spt_pkg::SPT_INT_PRIO_LSB +: 3] = irq_priority;
                end
                spt_pkg::SPT_OFS_STATUS: rd_next[spt_pkg::SPT_EVT_W-1:0] = status_reg;
                spt_pkg::SPT_OFS_MASK: rd_next[spt_pkg::SPT_EVT_W-1:0] = mask_reg;
                default: rd_next = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_data <= '0;
        end else begin
            rd_data <= rd_next;
        end
    end

endmodule : spt_timer

`default_nettype wire

// >>> pkg/spt_pkg.sv
// Package with register map, field layout and constants of the 16-bit period timer.
package spt_pkg;

    localparam int unsigned SPT_ADDR_W = 8;
    localparam int unsigned SPT_DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] SPT_OFS_CONTROL = 8'h00;
    localparam logic [7:0] SPT_OFS_PERIOD = 8'h04;
    localparam logic [7:0] SPT_OFS_COUNT = 8'h08;
    localparam logic [7:0] SPT_OFS_INT_CTRL = 8'h0C;
    localparam logic [7:0] SPT_OFS_STATUS = 8'h10;
    localparam logic [7:0] SPT_OFS_MASK = 8'h14;

    // Implemented bits of timer_control; the others read zero.
    localparam logic [15:0] SPT_CONTROL_WMASK = 16'hA376;
    localparam logic [15:0] SPT_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] SPT_PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] SPT_COUNT_RESET = 16'h0000;

    // Interrupt control register fields.
    localparam int unsigned SPT_INT_ENABLE_BIT = 0;
    localparam int unsigned SPT_INT_PRIO_LSB = 4;
    localparam logic [2:0] SPT_INT_PRIO_RESET = 3'h0;

    // Status and mask layout.
    localparam int unsigned SPT_EVT_W = 2;
    localparam int unsigned SPT_EVT_MATCH = 0;
    localparam int unsigned SPT_EVT_GATE_FALL = 1;
    localparam logic [1:0] SPT_EVT_RESET = 2'h0;

    // Prescale terminal counts for 1:1, 1:8, 1:64 and 1:256.
    localparam logic [7:0] SPT_PRE_LIMIT_1 = 8'h00;
    localparam logic [7:0] SPT_PRE_LIMIT_8 = 8'h07;
    localparam logic [7:0] SPT_PRE_LIMIT_64 = 8'h3F;
    localparam logic [7:0] SPT_PRE_LIMIT_256 = 8'hFF;

    typedef enum logic [1:0] {
        SPT_PRE_DIV1 = 2'b00,
        SPT_PRE_DIV8 = 2'b01,
        SPT_PRE_DIV64 = 2'b10,
        SPT_PRE_DIV256 = 2'b11
    } spt_prescale_t;

    typedef enum logic [1:0] {
        SPT_EXT_SECONDARY_OSC = 2'b00,
        SPT_EXT_CLOCK_INPUT = 2'b01,
        SPT_EXT_LOW_POWER_RC = 2'b10,
        SPT_EXT_GENERIC_TIMER = 2'b11
    } spt_ext_sel_t;

    typedef struct packed {
        logic timer_run;
        logic unused14;
        logic idle_stop;
        logic [2:0] unused12_10;
        spt_ext_sel_t extended_clock_select;
        logic unused7;
        logic gate_accumulate;
        spt_prescale_t prescale_select;
        logic unused3;
        logic external_clock_sync;
        logic clock_source_select;
        logic unused0;
    } spt_control_t;

    typedef struct packed {
        logic [SPT_ADDR_W-1:0] addr;
        logic [SPT_DATA_W-1:0] wr_data;
        logic wr_strobe;
        logic rd_strobe;
    } spt_bus_req_t;

    typedef struct packed {
        logic secondary_oscillator;
        logic low_power_rc_oscillator;
        logic external_clock_input;
        logic generic_timer_clock_input;
        logic gate_input;
    } spt_pins_t;

endpackage : spt_pkg

// >>> hw/spt_sync3.sv
// Three-stage pin synchroniser with an agreement filter on the last two stages.
`timescale 1ns/100ps
`default_nettype none

module spt_sync3 (
    input wire logic clock,
    input wire logic reset,
    input wire logic pin_in,
    output var logic level
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // The level follows only once the second and third stages agree.
    always_ff @(posedge clock) begin
        if (reset) begin
            level <= 1'b0;
        end else if (stage2_reg == stage3_reg) begin
            level <= stage3_reg;
        end
    end

endmodule : spt_sync3

`default_nettype wire

// >>> verification/spt_timer_assertions.sv
// Port-level assertions of the 16-bit period timer and their bind.
`timescale 1ns/100ps
`default_nettype none

module spt_timer_checker #(
    parameter int unsigned COUNT_W = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire spt_pkg::spt_bus_req_t bus_req,
    input wire logic [spt_pkg::SPT_DATA_W-1:0] rd_data,
    input wire spt_pkg::spt_pins_t pins,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic irq,
    input wire logic [2:0] irq_priority
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    // Shadows of the enable, mask and period registers, updated as writes land.
    logic en_reg;
    logic [1:0] mask_reg;
    logic [COUNT_W-1:0] per_reg;
    wire logic busy = bus_req.rd_strobe | bus_req.wr_strobe;
    wire logic rd_c = bus_req.rd_strobe;

    always_ff @(posedge clock) begin
        if (reset) begin
            en_reg <= 1'b0;
            mask_reg <= 2'h0;
            per_reg <= '1;
        end else if (bus_req.wr_strobe) begin
            if (bus_req.addr == spt_pkg::SPT_OFS_INT_CTRL) en_reg <= bus_req.wr_data[0];
            if (bus_req.addr == spt_pkg::SPT_OFS_MASK) mask_reg <= bus_req.wr_data[1:0];
            if (bus_req.addr == spt_pkg::SPT_OFS_PERIOD) per_reg <= bus_req.wr_data[COUNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_rd_idle;
        !$past(rd_c) |-> rd_data == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_ctrl_zero;
        rd_c && bus_req.addr == spt_pkg::SPT_OFS_CONTROL |=> (rd_data & ~32'h0000A376) == 32'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused control bit set");
    property p_prio;
        bus_req.wr_strobe && bus_req.addr == spt_pkg::SPT_OFS_INT_CTRL
            |-> ##2 irq_priority == $past(bus_req.wr_data[6:4], 2);
    endproperty
    a_prio: assert property (p_prio) else $error("priority not taken");
    property p_irq_off;
        !$past(en_reg) || $past(mask_reg) == 2'h0 |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled or masked");
    property p_count_max;
        rd_c && bus_req.addr == spt_pkg::SPT_OFS_COUNT
            |=> rd_data <= {{(32-COUNT_W){1'b0}}, per_reg};
    endproperty
    a_count_max: assert property (p_count_max) else $error("count above period");
    property p_unmapped;
        rd_c && bus_req.addr > spt_pkg::SPT_OFS_MASK |=> rd_data == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_irq_hold;
        irq && !$past(busy) && !busy |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
    property p_stat_bits;
        rd_c && bus_req.addr == spt_pkg::SPT_OFS_STATUS |=> rd_data[31:2] == 30'h0;
    endproperty
    a_stat_bits: assert property (p_stat_bits) else $error("status high bits set");
endmodule : spt_timer_checker

bind spt_timer spt_timer_checker #(.COUNT_W(COUNT_W)) u_spt_timer_checker (
    .clock(clock), .reset(reset), .bus_req(bus_req), .rd_data(rd_data), .pins(pins),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq), .irq_priority(irq_priority));

`default_nettype wire

// >>> verification/spt_timer_test.sv
// Self-checking testbench of the 16-bit period timer.
`timescale 1ns/100ps
`default_nettype none

module spt_timer_test;
    logic clock, reset, irq, cpu_idle, cpu_sleep, pend;
    logic [2:0] irq_priority;
    logic [31:0] rd_data, seed, lo;
    logic [63:0] exp_q[$];
    logic [63:0] exp;
    spt_pkg::spt_bus_req_t bus_req;
    spt_pkg::spt_pins_t pins, p;
    int err_total, num_checks, k, i;
    int pidx[4] = '{4, 2, 3, 1};

    spt_timer u_spt_timer (.clock(clock), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
        .pins(pins), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq),
        .irq_priority(irq_priority));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic bad(input string m);
        err_total++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask : bad

    task automatic chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) bad(m);
    endtask : chk

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    // Each bus cycle is followed by one idle cycle so no strobe is set twice in a step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req.addr <= a;
        bus_req.wr_data <= d;
        bus_req.wr_strobe <= 1'b1;
        @(posedge clock);
        bus_req.wr_strobe <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] l, input logic [31:0] h);
        exp_q.push_back({h, l});
        bus_req.addr <= a;
        bus_req.rd_strobe <= 1'b1;
        @(posedge clock);
        bus_req.rd_strobe <= 1'b0;
        @(posedge clock);
    endtask : rd

    task automatic wait_irq;
        for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clock);
        chk(irq === 1'b1, "irq timeout");
        if (irq !== 1'b1) results();
    endtask : wait_irq

    // Read data are compared in the cycle after the strobe, against a range.
    always @(posedge clock) begin
        if (pend) begin
            exp = exp_q.pop_front();
            num_checks++;
            if ((rd_data >= exp[31:0] && rd_data <= exp[63:32]) !== 1'b1) bad("read value");
        end
        pend <= bus_req.rd_strobe;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        bus_req = '0;
        pins = '0;
        cpu_idle = 1'b0;
        cpu_sleep = 1'b0;
        reset = 1'b1;
        err_total = 0;
        num_checks = 0;
        seed = 32'h0000FB98;
        cyc(20);
        reset <= 1'b0;
        for (k = 0; k < 7; k++) rd(8'(4 * k), k == 1 ? 32'hFFFF : 0, k == 1 ? 32'hFFFF : 0);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'hA376, 32'hA376);
        wr(8'h00, 0);
        $display("test 1 done");
        cpu_idle <= 1'b1;
        for (k = 0; k < 5; k++) begin
            wr(8'h08, 0);
            wr(8'h00, {16'h0, 1'b1, 1'b0, k == 4, 7'h0, 2'(k), 4'h0});
            cyc(k == 3 ? 4096 : 16 << (3 * (k & 3)));
            wr(8'h00, 0);
            cyc(40);
            lo = k < 4 ? 7 : 0;
            rd(8'h08, lo, k < 4 ? 9 : 0);
        end
        cpu_idle <= 1'b0;
        $display("test 2 done");
        wr(8'h08, 0);
        for (k = 0; k < 6; k++) begin
            wr(8'h00, 32'h8030);
            cyc(200);
        end
        wr(8'h00, 0);
        rd(8'h08, 0, 0);
        $display("test 3 done");
        wr(8'h04, 3);
        wr(8'h0C, 32'h51);
        wr(8'h00, 32'h8000);
        cyc(40);
        chk(irq === 1'b0, "masked irq");
        chk(irq_priority === 3'h5, "priority");
        wr(8'h14, 1);
        wait_irq();
        cyc(4);
        wr(8'h00, 0);
        rd(8'h08, 0, 3);
        rd(8'h10, 1, 1);
        rd(8'h10, 0, 0);
        cyc(3);
        chk(irq === 1'b0, "irq after clear");
        wr(8'h08, 0);
        wr(8'h04, 32'hFFFF);
        $display("test 4 done");
        wr(8'h14, 3);
        wr(8'h00, 32'h8040);
        cyc(40);
        pins.gate_input <= 1'b1;
        cyc(40);
        pins.gate_input <= 1'b0;
        wait_irq();
        wr(8'h00, 0);
        rd(8'h08, 18, 21);
        rd(8'h10, 2, 2);
        $display("test 5 done");
        for (k = 0; k < 4; k++) begin
            cpu_sleep <= k[1];
            wr(8'h08, 0);
            wr(8'h00, {16'h0, 6'h20, 2'(k), 5'h0, k[0], 2'h2});
            for (i = 0; i < 168; i++) begin
                seed = xs(seed);
                p = seed[4:0];
                p[pidx[k]] = (i / 8) % 2 == 1 && i < 160;
                pins <= p;
                @(posedge clock);
            end
            wr(8'h00, 0);
            pins <= '0;
            rd(8'h08, k == 3 ? 0 : 10, k == 3 ? 0 : 10);
        end
        cpu_sleep <= 1'b0;
        $display("test 6 done");
        cyc(4);
        results();
    end
endmodule : spt_timer_test

`default_nettype wire
